// file: rtl/wdt_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Register indices as printed; byte address is four times the index
`define WDT_IDX_CTRL 16'h4004
`define WDT_IDX_STAT 16'h4011
`define WDT_IDX_MASK 16'h4019
`define WDT_IDX_SEC 16'h4008
`define WDT_ADDR_W 18
`define WDT_ADDR_CTRL 18'h10010
`define WDT_ADDR_STAT 18'h10044
`define WDT_ADDR_MASK 18'h10064
`define WDT_ADDR_SEC 18'h10020

// Control field positions
`define WDT_BIT_ENABLE 15
`define WDT_BIT_PAUSE 14
`define WDT_BIT_SRC 13
`define WDT_BIT_SLPRUN 12
`define WDT_BIT_SWRST 11
`define WDT_SEC_HI 9
`define WDT_SEC_LO 8
`define WDT_PRI_HI 5
`define WDT_PRI_LO 4
`define WDT_TO_HI 2
`define WDT_TO_LO 0
`define WDT_CTRL_WMASK 16'hf337
`define WDT_CTRL_RST 16'ha217

// Status and mask
`define WDT_BIT_TOFLAG 11
`define WDT_MASK_RST 1'h1

// Timing
`define WDT_BASE_PERIOD_US 256000
`define WDT_CLK_PERIOD_NS 20
`define WDT_RESET_HOLD_CYC 16
`define WDT_MAX_ATTEMPTS 3'h6
`define WDT_USER_KEY 16'h9c5e

`endif

// file: rtl/wdt_pkg.sv
// Types shared by the watchdog block
package wdt_pkg;

    typedef enum logic [1:0] {
        ST_FIRST = 2'b00,
        ST_SECOND = 2'b01,
        ST_RESET = 2'b10,
        ST_OFF = 2'b11
    } wdt_state_t;

    typedef enum logic [1:0] {
        ACT_NONE = 2'b00,
        ACT_IRQ = 2'b01,
        ACT_RESET = 2'b10,
        ACT_WAKE = 2'b11
    } wdt_action_t;

endpackage : wdt_pkg

// file: rtl/wdt_watchdog.sv
// Watchdog timer with APB registers, two-stage actions and reset limit
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_watchdog #(
    parameter int unsigned BASE_CYCLES =
        `WDT_BASE_PERIOD_US * 1000 / `WDT_CLK_PERIOD_NS,
    parameter int unsigned RESET_HOLD = `WDT_RESET_HOLD_CYC,
    // Arbitrary unlock code
    parameter logic [15:0] USER_KEY = `WDT_USER_KEY
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [`WDT_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device side
    input wire logic sleep_state,
    input wire logic hw_restart_in,
    input wire logic power_on_event,
    output logic device_reset_out,
    output logic wake_req,
    output logic off_state,
    output logic primary_timeout_irq
);

    localparam int SYN_N = 3;

    logic [SYN_N-1:0] async_in, sync1_r, sync2_r, sync3_r;
    logic sleep_s, hw_toggle, on_rise;

    logic [15:0] ctrl_r;
    logic unlock_r, flag_r, mask_r, wake_r, rst_out_r, off_r;
    logic [30:0] cnt_r, limit;
    logic [2:0] attempts_r;
    logic [15:0] hold_r;
    wdt_pkg::wdt_state_t state_r, state_nxt;
    wdt_pkg::wdt_action_t act;

    logic access, wr, ctrl_wr, sw_restart, hw_restart, restart;
    logic hit_ctrl, hit_stat, hit_mask, hit_sec;
    logic en_rise, active, running, expire, wd_reset_go;
    logic flag_set, flag_clr;

    // Input synchronisers, one per pin
    assign async_in = {power_on_event, hw_restart_in, sleep_state};

    genvar gi;
    generate
        for (gi = 0; gi < SYN_N; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                end
            end
        end
    endgenerate

    assign sleep_s = sync2_r[0];
    assign hw_toggle = sync2_r[1] ^ sync3_r[1];
    assign on_rise = sync2_r[2] & ~sync3_r[2];

    // APB decode; zero wait states
    assign pready = 1'b1;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign hit_ctrl = (paddr == `WDT_ADDR_CTRL);
    assign hit_stat = (paddr == `WDT_ADDR_STAT);
    assign hit_mask = (paddr == `WDT_ADDR_MASK);
    assign hit_sec = (paddr == `WDT_ADDR_SEC);
    assign pslverr = access & ~(hit_ctrl | hit_stat | hit_mask | hit_sec);

    assign ctrl_wr = wr & hit_ctrl & unlock_r;

    assign sw_restart = ctrl_wr & pwdata[`WDT_BIT_SWRST] &
        ctrl_r[`WDT_BIT_SRC];
    assign hw_restart = hw_toggle & ~ctrl_r[`WDT_BIT_SRC];
    assign restart = sw_restart | hw_restart;

    // only a 0 to 1 change starts
    assign en_rise = ctrl_wr & pwdata[`WDT_BIT_ENABLE] &
        ~ctrl_r[`WDT_BIT_ENABLE];

    assign active = (state_r == wdt_pkg::ST_FIRST) |
        (state_r == wdt_pkg::ST_SECOND);
    assign running = active & ctrl_r[`WDT_BIT_ENABLE] &
        ~ctrl_r[`WDT_BIT_PAUSE] & (~sleep_s | ctrl_r[`WDT_BIT_SLPRUN]);

    assign limit = 31'(BASE_CYCLES) << ctrl_r[`WDT_TO_HI:`WDT_TO_LO];
    assign expire = running & (cnt_r >= limit - 31'h1) & ~restart;

    always_comb begin
        if (state_r == wdt_pkg::ST_SECOND) begin
            act = wdt_pkg::wdt_action_t'(ctrl_r[`WDT_SEC_HI:`WDT_SEC_LO]);
        end else begin
            act = wdt_pkg::wdt_action_t'(ctrl_r[`WDT_PRI_HI:`WDT_PRI_LO]);
        end
    end

    assign wd_reset_go = expire & (act == wdt_pkg::ACT_RESET);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 31'h0;
        end else if (!active || restart || en_rise || expire) begin
            cnt_r <= 31'h0;
        end else if (running) begin
            cnt_r <= cnt_r + 31'h1;
        end
    end

    // Stage and reset sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            wdt_pkg::ST_FIRST, wdt_pkg::ST_SECOND: begin
                if (wd_reset_go) begin
                    if (attempts_r >= `WDT_MAX_ATTEMPTS) begin
                        state_nxt = wdt_pkg::ST_OFF;
                    end else begin
                        state_nxt = wdt_pkg::ST_RESET;
                    end
                end else if (expire) begin
                    state_nxt = wdt_pkg::ST_SECOND;
                end else if (restart) begin
                    state_nxt = wdt_pkg::ST_FIRST;
                end
            end
            wdt_pkg::ST_RESET: begin
                if (hold_r >= 16'(RESET_HOLD - 1)) begin
                    state_nxt = wdt_pkg::ST_FIRST;
                end
            end
            wdt_pkg::ST_OFF: begin
                if (on_rise) begin
                    state_nxt = wdt_pkg::ST_FIRST;
                end
            end
            default: state_nxt = wdt_pkg::ST_FIRST;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= wdt_pkg::ST_FIRST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Reset hold timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 16'h0;
        end else if (state_r == wdt_pkg::ST_RESET) begin
            hold_r <= hold_r + 16'h1;
        end else begin
            hold_r <= 16'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            attempts_r <= 3'h0;
        end else if (state_r == wdt_pkg::ST_OFF && on_rise) begin
            attempts_r <= 3'h0;
        end else if (state_r != wdt_pkg::ST_RESET &&
                     state_nxt == wdt_pkg::ST_RESET) begin
            attempts_r <= attempts_r + 3'h1;
        end
    end

    // reset output, wake pulse, off level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_out_r <= 1'b0;
            wake_r <= 1'b0;
            off_r <= 1'b0;
        end else begin
            rst_out_r <= (state_nxt == wdt_pkg::ST_RESET) |
                (state_nxt == wdt_pkg::ST_OFF);
            wake_r <= expire & (act == wdt_pkg::ACT_WAKE);
            off_r <= (state_nxt == wdt_pkg::ST_OFF);
        end
    end

    assign device_reset_out = rst_out_r;
    assign wake_req = wake_r;
    assign off_state = off_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `WDT_CTRL_RST;
        end else if (wd_reset_go) begin
            ctrl_r <= `WDT_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_r <= pwdata[15:0] & `WDT_CTRL_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_r <= 1'b0;
        end else if (wd_reset_go) begin
            unlock_r <= 1'b0;
        end else if (wr && hit_sec) begin
            unlock_r <= (pwdata[15:0] == USER_KEY);
        end
    end

    // sticky flag, set wins over clear
    assign flag_set = expire & (act == wdt_pkg::ACT_IRQ);
    assign flag_clr = wr & hit_stat & pwdata[`WDT_BIT_TOFLAG];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_set | (flag_r & ~flag_clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= `WDT_MASK_RST;
        end else if (wd_reset_go) begin
            mask_r <= `WDT_MASK_RST;
        end else if (wr && hit_mask) begin
            mask_r <= pwdata[`WDT_BIT_TOFLAG];
        end
    end

    assign primary_timeout_irq = flag_r & ~mask_r;

    // Read data captured in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0;
            if (hit_ctrl) begin
                prdata[15:0] <= ctrl_r;
            end else if (hit_stat) begin
                prdata[`WDT_BIT_TOFLAG] <= flag_r;
            end else if (hit_mask) begin
                prdata[`WDT_BIT_TOFLAG] <= mask_r;
            end else if (hit_sec) begin
                prdata[0] <= unlock_r;
            end
        end
    end

    // Checks
    localparam int HOLD_BOUND = 64;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_accepted_restart;
        restart && active;
    endsequence

    sequence s_enter_reset;
        state_r != wdt_pkg::ST_RESET && state_nxt == wdt_pkg::ST_RESET;
    endsequence

    sequence s_frozen_cycle;
        active && !restart && !en_rise && !expire;
    endsequence

    a_restart_clears: assert property (
        s_accepted_restart |=> cnt_r == 31'h0)
        else $error("count not cleared by restart");

    a_wrong_path: assert property (
        ctrl_wr && pwdata[`WDT_BIT_SWRST] && !ctrl_r[`WDT_BIT_SRC] &&
        !hw_toggle && running && !expire && !en_rise
        |=> cnt_r == $past(cnt_r) + 31'h1)
        else $error("deselected software restart acted");

    a_enable_stops: assert property (
        s_frozen_cycle and !ctrl_r[`WDT_BIT_ENABLE] |=> $stable(cnt_r))
        else $error("count moved while disabled");

    a_pause_freezes: assert property (
        s_frozen_cycle and ctrl_r[`WDT_BIT_PAUSE] |=> $stable(cnt_r))
        else $error("count moved while paused");

    a_sleep_stops: assert property (
        s_frozen_cycle and sleep_s && !ctrl_r[`WDT_BIT_SLPRUN]
        |=> $stable(cnt_r))
        else $error("count moved in sleep");

    a_first_irq: assert property (
        expire && state_r == wdt_pkg::ST_FIRST &&
        ctrl_r[`WDT_PRI_HI:`WDT_PRI_LO] == 2'b01
        |=> flag_r && state_r == wdt_pkg::ST_SECOND)
        else $error("first action not taken");

    a_reset_entry: assert property (
        s_enter_reset |=> device_reset_out && ctrl_r == `WDT_CTRL_RST
        && !unlock_r)
        else $error("device reset not applied");

    a_reset_ends: assert property (
        s_enter_reset |=> ##[1:HOLD_BOUND] state_r == wdt_pkg::ST_FIRST)
        else $error("no return to first stage");

    a_attempt_cap: assert property (
        wd_reset_go && attempts_r == `WDT_MAX_ATTEMPTS
        |=> off_state && state_r == wdt_pkg::ST_OFF)
        else $error("reset attempts exceeded");

    a_key_lock: assert property (
        wr && hit_ctrl && !unlock_r && !wd_reset_go |=> $stable(ctrl_r))
        else $error("locked control changed");

    a_set_wins: assert property (
        flag_set && flag_clr |=> flag_r)
        else $error("timeout flag lost");

endmodule : wdt_watchdog

// file: tb/wdt_host.sv
// Host model that toggles the watchdog restart pin
`timescale 1ns/1ps

module wdt_host (
    // Clock and control
    input wire logic pclk,
    input wire logic run,
    // Restart pin
    output logic hw_restart_in
);
    logic [1:0] gap_r = 2'h0;
    logic level_r = 1'b0;

    assign hw_restart_in = level_r;

    always @(posedge pclk) begin
        if (run) begin
            gap_r <= gap_r + 2'h1;
            if (gap_r == 2'h3) begin
                level_r <= !level_r;
            end
        end
    end
endmodule : wdt_host

// file: tb/wdt_watchdog_tb.sv
// Self-checking bench for the watchdog block
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_watchdog_tb;
    localparam logic [17:0] A_CT = `WDT_ADDR_CTRL;
    localparam logic [17:0] A_ST = `WDT_ADDR_STAT;
    localparam logic [17:0] A_MK = `WDT_ADDR_MASK;
    localparam logic [17:0] A_SC = `WDT_ADDR_SEC;
    localparam logic [31:0] FL = 32'h00000800;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic sleep_state = 1'b0;
    logic power_on_event = 1'b0;
    logic run = 1'b0;
    logic rst_q = 1'b0;
    logic err;
    logic [31:0] rdv;
    logic [31:0] prdata;
    logic pready, pslverr, hw_restart_in, device_reset_out;
    logic wake_req, off_state, primary_timeout_irq;
    int n_mismatch = 0;
    int compares = 0;
    int n_rst = 0;
    int n_wake = 0;
    int cyc = 0;
    int i;

    always #10 pclk = ~pclk;

    wdt_watchdog #(.BASE_CYCLES(8)) u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .sleep_state(sleep_state),
        .hw_restart_in(hw_restart_in),
        .power_on_event(power_on_event),
        .device_reset_out(device_reset_out),
        .wake_req(wake_req),
        .off_state(off_state),
        .primary_timeout_irq(primary_timeout_irq)
    );

    wdt_host u_host (
        .pclk(pclk),
        .run(run),
        .hw_restart_in(hw_restart_in)
    );

    task automatic finish_test;
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // Reset and wake event counts, hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        rst_q <= device_reset_out;
        if (device_reset_out && !rst_q && !off_state) begin
            n_rst <= n_rst + 1;
        end
        if (wake_req) begin
            n_wake <= n_wake + 1;
        end
        if (cyc == 40000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic xfer(input logic [17:0] a, input logic w,
                        input logic [15:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= {16'h0, d};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [17:0] a, input logic [15:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [17:0] a);
        xfer(a, 1'b0, 16'h0);
    endtask : rd

    task automatic sts(input logic [31:0] e);
        rd(A_ST);
        chk("status", e, rdv);
    endtask : sts

    task automatic clr;
        wr(A_ST, 16'h0800);
    endtask : clr

    task automatic t_regs;
        rd(A_CT);
        chk("ctrl", 32'h0000a217, rdv);
        rd(A_MK);
        chk("mask", FL, rdv);
        sts(32'h0);
        rd(18'h00100);
        chk("unmapped err", 32'h1, {31'h0, err});
        wr(A_CT, 16'h0000);
        rd(A_CT);
        chk("locked ctrl", 32'h0000a217, rdv);
        wr(A_SC, `WDT_USER_KEY);
        wr(A_CT, 16'ha810);
        rd(A_CT);
        chk("ctrl", 32'h0000a010, rdv);
    endtask : t_regs

    task automatic t_irq;
        wr(A_MK, 16'h0000);
        wr(A_CT, 16'ha810);
        clr();
        repeat (8) wr(A_CT, 16'ha810);
        sts(32'h0);
        tick(2);
        // Clear lands on the expiry edge; the set must win
        clr();
        tick(8);
        sts(FL);
        chk("irq", 32'h1, {31'h0, primary_timeout_irq});
        wr(A_MK, 16'h0800);
        chk("irq masked", 32'h0, {31'h0, primary_timeout_irq});
        wr(A_MK, 16'h0000);
        clr();
        sts(32'h0);
        chk("irq clear", 32'h0, {31'h0, primary_timeout_irq});
    endtask : t_irq

    task automatic t_stop;
        wr(A_CT, 16'he810);
        clr();
        tick(40);
        sts(32'h0);
        wr(A_CT, 16'ha010);
        tick(12);
        sts(FL);
        wr(A_CT, 16'ha810);
        clr();
        repeat (6) wr(A_CT, 16'ha010);
        sts(FL);
        wr(A_CT, 16'h2810);
        clr();
        tick(40);
        sts(32'h0);
        wr(A_CT, 16'ha010);
        tick(12);
        sts(FL);
    endtask : t_stop

    task automatic t_sleep;
        sleep_state <= 1'b1;
        wr(A_CT, 16'ha810);
        clr();
        tick(40);
        sts(32'h0);
        wr(A_CT, 16'hb010);
        tick(12);
        sts(FL);
        sleep_state <= 1'b0;
    endtask : t_sleep

    task automatic t_hw;
        wr(A_CT, 16'h2810);
        clr();
        // Enabling clears the count, so only ignored restarts end it
        wr(A_CT, 16'h8010);
        repeat (6) wr(A_CT, 16'h8810);
        sts(FL);
        run <= 1'b1;
        tick(8);
        clr();
        tick(60);
        sts(32'h0);
        run <= 1'b0;
        tick(20);
        sts(FL);
        wr(A_CT, 16'ha810);
    endtask : t_hw

    task automatic t_act;
        wr(A_CT, 16'ha830);
        clr();
        i = n_wake;
        tick(12);
        chk("wake pulses", 32'h1, 32'(n_wake - i));
        sts(32'h0);
        wr(A_CT, 16'ha900);
        clr();
        tick(8);
        sts(32'h0);
        tick(8);
        sts(FL);
    endtask : t_act

    task automatic t_limit;
        wr(A_CT, 16'ha820);
        clr();
        for (i = 0; i < 5000 && n_rst < 2; i++) @(posedge pclk);
        for (i = 0; i < 100 && device_reset_out; i++) @(posedge pclk);
        sts(FL);
        rd(A_CT);
        chk("ctrl after reset", 32'h0000a217, rdv);
        rd(A_MK);
        chk("mask after reset", FL, rdv);
        for (i = 0; i < 20000 && !off_state; i++) @(posedge pclk);
        chk("resets", 32'h6, 32'(n_rst));
        chk("reset pin", 32'h1, {31'h0, device_reset_out});
        power_on_event <= 1'b1;
        tick(6);
        chk("off", 32'h0, {31'h0, off_state});
        power_on_event <= 1'b0;
    endtask : t_limit

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_irq();
        t_stop();
        t_sleep();
        t_hw();
        t_act();
        t_limit();
        finish_test();
    end
endmodule : wdt_watchdog_tb
